// *** hdl/phase_corr_pkg.sv ***
// constants and register map for the phase temperature correction stage
package phase_corr_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SUPP_OFFSET = 8'hF5;
    localparam logic [7:0] IDX_CTRL = 8'hF6;
    localparam logic [7:0] IDX_EMIT_COEFF = 8'hF7;
    localparam logic [7:0] IDX_CAL_TEMPS = 8'hF8;
    localparam logic [7:0] IDX_BASE_OFFSET = 8'hF9;
    // reset values
    localparam logic [23:0] CTRL_RESET = 24'h880000;
    localparam logic [23:0] BASE_RESET = 24'h080000;
    localparam logic [23:0] ZERO_RESET = 24'h000000;
    // field positions
    localparam int OFFSET_MSB = 12;
    localparam int COEFF_MSB = 16;
    localparam int PREC_MSB = 23;
    localparam int PREC_LSB = 20;
    localparam int SAT_BIT = 19;
    localparam int TEMP_OFF_BIT = 18;
    localparam int CONST_OFF_BIT = 17;
    localparam int SPARE_MSB = 23;
    localparam int SPARE_LSB = 16;
    localparam int EMIT_REF_MSB = 15;
    localparam int EMIT_REF_LSB = 8;
    localparam int DIE_REF_MSB = 7;
    localparam int DIE_REF_LSB = 0;
    // precision value that leaves the coefficient unscaled
    localparam logic [3:0] PREC_UNITY = 4'h8;
    // width of the correction sum
    localparam int CORR_W = 36;
    // pipeline latency from phase_in to phase_out, in cycles
    localparam int PIPE_LATENCY = 2;
endpackage

// *** hdl/phase_temp_correction.sv ***
// phase correction stage with ahb-lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module phase_temp_correction
    import phase_corr_pkg::*;
#(
    parameter int PHASE_WIDTH = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [PHASE_WIDTH-1:0] phase_in,
    input wire logic phase_in_valid,
    input wire logic supplementary_frame,
    input wire logic [7:0] emitter_temperature,
    input wire logic [7:0] die_temperature,
    output logic [PHASE_WIDTH-1:0] phase_out,
    output logic phase_out_valid
);

    ////////////////////////////////////////////////////////////////////
    // state
    ////////////////////////////////////////////////////////////////////

    // two pipeline stages carry the phase stream: stage one latches the
    // sample and its full correction, stage two adds and clips, so a
    // corrected value leaves exactly two edges after it arrives
    // the bus side keeps one pending address phase and the read word
    // that stands on hrdata during the following data phase
    //
    // every flip-flop of the block lives in this one record
    typedef struct packed {
        logic a_valid;                    // bus data phase pending
        logic a_wr;                       // pending phase is a write
        logic a_hit;                      // pending address is mapped
        logic [7:0] a_idx;                // register index of pending
        logic [31:0] rdata;               // read data for data phase
        logic [12:0] supp_offset;         // supplementary frame offset
        logic [23:0] ctrl;                // precision, flags, die coeff
        logic [16:0] emit_coeff;          // emitter coefficient
        logic [23:0] cal_temps;           // spare byte and references
        logic [23:0] base_reg;            // base frame offset register
        logic s1_valid;                   // stage one holds a sample
        logic [PHASE_WIDTH-1:0] s1_phase; // phase delayed one stage
        logic [CORR_W-1:0] s1_corr;       // total correction
        logic s2_valid;                   // output sample valid
        logic [PHASE_WIDTH-1:0] s2_phase; // corrected phase
    } state_type;

    state_type q;  // registered state
    state_type d;  // next state

    ////////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////////

    // scale a programmed coefficient by the precision field
    // unity is eight; fifteen moves a full 17-bit coefficient to the top
    // of the 24-bit result, so the scaled value can never overflow
    // below unity the shift turns arithmetic right, losing low bits
    function automatic logic signed [23:0] scale_coeff(
        input logic [16:0] coeff,
        input logic [3:0] prec
    );
        logic signed [23:0] wide;
        logic [3:0] amount;
        // sign-extend first so the left shift keeps the sign
        wide = $signed({{7{coeff[16]}}, coeff});
        if (prec >= PREC_UNITY) begin
            amount = prec - PREC_UNITY;
            scale_coeff = wide <<< amount;
        end else begin
            amount = PREC_UNITY - prec;
            scale_coeff = wide >>> amount;
        end
    endfunction

    // signed difference of live and reference temperatures
    function automatic logic signed [8:0] temp_delta(
        input logic [7:0] live,
        input logic [7:0] ref_temp
    );
        // nine bits hold any difference of two signed bytes, so no wrap
        temp_delta = $signed({live[7], live}) - $signed({ref_temp[7], ref_temp});
    endfunction

    // one temperature term: scaled coefficient times delta
    function automatic logic signed [CORR_W-1:0] temp_term(
        input logic [16:0] coeff,
        input logic [3:0] prec,
        input logic [7:0] live,
        input logic [7:0] ref_temp
    );
        logic signed [32:0] prod;
        // 24-bit scaled coefficient by 9-bit delta fits 33 bits exactly
        // the product is then sign-extended to the correction width
        prod = scale_coeff(coeff, prec) * temp_delta(live, ref_temp);
        temp_term = CORR_W'(prod);
    endfunction

    // a transfer request seen in an address phase
    // nonseq and seq both carry bit one of htrans; idle and busy do not
    function automatic logic bus_request(
        input logic sel,
        input logic [1:0] trans
    );
        bus_request = sel && trans[1];
    endfunction

    // address lies in the word range that this block decodes
    // only address bits 9:2 select a register; bits 31:10 must be zero
    function automatic logic in_map(
        input logic [31:0] addr
    );
        in_map = (addr[31:10] == 22'h000000);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    ////////////////////////////////////////////////////////////////////

    // control fields pulled out for readability
    // they are plain wires of the comb process, not extra flip-flops;
    // a register write shows in the correction one edge after it lands
    logic [3:0] prec;
    logic sat_on;
    logic temp_off;
    logic const_off;
    logic [16:0] die_coeff;
    logic [12:0] frame_offset;
    logic signed [CORR_W-1:0] offset_term;
    logic signed [CORR_W-1:0] emit_term;
    logic signed [CORR_W-1:0] die_term;
    logic signed [CORR_W:0] sum;
    logic signed [CORR_W:0] phase_max;

    always_comb begin
        prec = q.ctrl[PREC_MSB:PREC_LSB];
        sat_on = q.ctrl[SAT_BIT];
        temp_off = q.ctrl[TEMP_OFF_BIT];
        const_off = q.ctrl[CONST_OFF_BIT];
        die_coeff = q.ctrl[COEFF_MSB:0];
        phase_max = (CORR_W+1)'({PHASE_WIDTH{1'b1}});
        // start from the held state; every branch below changes only what
        // it owns, which keeps the process free of latches
        d = q;

        // ---- bus address phase ----
        // reads are fetched here so hrdata stands for the data phase
        // a read right behind a write to the same register would see
        // the old value; the single-transfer master never does that
        // an address phase is only taken while hready is high; while it is
        // low the pending phase and the read word are held as they are
        if (hready) begin
            // latch what the data phase will need one edge later
            d.a_valid = bus_request(hsel, htrans);
            d.a_wr = hwrite;
            d.a_idx = haddr[9:2];
            d.a_hit = in_map(haddr);
            // hrdata falls back to zero unless a mapped read was taken
            d.rdata = 32'h00000000;
            if (bus_request(hsel, htrans) && !hwrite && in_map(haddr)) begin
                case (haddr[9:2])
                    // unstored upper bits read back as zero
                    IDX_SUPP_OFFSET: begin
                        d.rdata = {19'h00000, q.supp_offset};
                    end
                    IDX_CTRL: begin
                        d.rdata = {8'h00, q.ctrl};
                    end
                    IDX_EMIT_COEFF: begin
                        d.rdata = {15'h0000, q.emit_coeff};
                    end
                    IDX_CAL_TEMPS: begin
                        d.rdata = {8'h00, q.cal_temps};
                    end
                    IDX_BASE_OFFSET: begin
                        d.rdata = {8'h00, q.base_reg};
                    end
                    // unmapped words read as zero
                    default: begin
                        d.rdata = 32'h00000000;
                    end
                endcase
            end
        end

        // ---- bus data phase: writes land here ----
        // hwdata is valid only in the cycle after the address phase, so the
        // store uses the captured index, never the live address lines
        // only bits 23:0 of the word are ever kept; the top byte is dropped
        if (q.a_valid && q.a_wr && q.a_hit) begin
            case (q.a_idx)
                IDX_SUPP_OFFSET: begin
                    // upper bits are not stored, so stray ones are harmless
                    d.supp_offset = hwdata[OFFSET_MSB:0];
                end
                IDX_CTRL: begin
                    // saturate bit is stored as written; clearing it wraps
                    d.ctrl = hwdata[23:0];
                end
                IDX_EMIT_COEFF: begin
                    d.emit_coeff = hwdata[COEFF_MSB:0];
                end
                IDX_CAL_TEMPS: begin
                    // spare byte shares the word and steers nothing
                    d.cal_temps = hwdata[23:0];
                end
                IDX_BASE_OFFSET: begin
                    d.base_reg = hwdata[23:0];
                end
                // unmapped writes are dropped with an okay response
                default: begin
                    d.base_reg = q.base_reg;
                end
            endcase
        end

        // ---- stage one: build the total correction ----
        // the frame flag and both temperatures are taken on the same edge
        // as the phase sample, so each pixel is corrected with the values
        // that stood beside it; nothing here waits or stalls
        // offset chosen by frame type
        if (supplementary_frame) begin
            frame_offset = q.supp_offset;
        end else begin
            frame_offset = q.base_reg[OFFSET_MSB:0];
        end
        // constant term, sign-extended
        if (const_off) begin
            offset_term = '0;
        end else begin
            offset_term = CORR_W'($signed(frame_offset));
        end
        // temperature terms against stored references
        // a precision below eight shifts right and drops low coefficient
        // bits; software trades range for resolution with that field
        if (temp_off) begin
            emit_term = '0;
            die_term = '0;
        end else begin
            // emitter reading is a signed sensor byte
            emit_term = temp_term(q.emit_coeff, prec, emitter_temperature,
                q.cal_temps[EMIT_REF_MSB:EMIT_REF_LSB]);
            die_term = temp_term(die_coeff, prec, die_temperature,
                q.cal_temps[DIE_REF_MSB:DIE_REF_LSB]);
        end
        // no enable and no back-pressure: the stream never stalls
        // every sample advances one stage per cycle
        d.s1_valid = phase_in_valid;
        d.s1_phase = phase_in;
        d.s1_corr = offset_term + emit_term + die_term;

        // ---- stage two: apply correction to phase ----
        // the raw phase is unsigned, so it is zero-extended before the
        // signed add; the sum is one bit wider than the correction so the
        // largest correction plus the largest phase cannot overflow
        sum = $signed({{(CORR_W+1-PHASE_WIDTH){1'b0}}, q.s1_phase})
            + (CORR_W+1)'($signed(q.s1_corr));
        d.s2_valid = q.s1_valid;
        if (sat_on) begin
            // clip to the phase range instead of wrapping
            // clipping keeps a near-zero phase from jumping to the far end
            if (sum < 0) begin
                d.s2_phase = '0;
            end else if (sum > phase_max) begin
                d.s2_phase = {PHASE_WIDTH{1'b1}};
            end else begin
                d.s2_phase = sum[PHASE_WIDTH-1:0];
            end
        end else begin
            // without clipping the sum wraps modulo the phase range
            d.s2_phase = sum[PHASE_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////////

    // single clocked process for all state
    // the reset branch lists each field so every register gets a constant;
    // control resets to unity precision with clipping on, the other
    // correction registers clear except bit 19 of base_reg, so a fresh block passes phase unchanged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q.a_valid <= 1'b0;
            q.a_wr <= 1'b0;
            q.a_hit <= 1'b0;
            q.a_idx <= 8'h00;
            q.rdata <= 32'h00000000;
            q.supp_offset <= 13'h0000;
            q.ctrl <= CTRL_RESET;
            q.emit_coeff <= 17'h00000;
            q.cal_temps <= ZERO_RESET;
            q.base_reg <= BASE_RESET;
            q.s1_valid <= 1'b0;
            q.s1_phase <= '0;
            q.s1_corr <= '0;
            q.s2_valid <= 1'b0;
            q.s2_phase <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////

    // the slave never stretches a transfer and never errors
    // hrdata comes straight from a flip-flop, so it is clean for the whole
    // data phase and reads zero between transfers
    // the phase outputs are registered as well; valid marks each sample
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign phase_out = q.s2_phase;
    assign phase_out_valid = q.s2_valid;

endmodule

// *** test/phase_corr_monitor.sv ***
// port-level assertions for the phase correction stage
`timescale 1ns/1ps
module phase_corr_monitor
    import phase_corr_pkg::*;
#(
    parameter int PHASE_WIDTH = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [PHASE_WIDTH-1:0] phase_in,
    input wire logic phase_in_valid,
    input wire logic supplementary_frame,
    input wire logic [7:0] emitter_temperature,
    input wire logic [7:0] die_temperature,
    input wire logic [PHASE_WIDTH-1:0] phase_out,
    input wire logic phase_out_valid
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_dp_q; // read data phase under way
    logic wr_dp_q; // write data phase, register lands at its end
    logic [7:0] idx_q; // register index of the data phase
    ////////////////////////////////////////////////////////////////
    // track data phases one cycle behind the taken address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp_q <= 1'b0;
            wr_dp_q <= 1'b0;
            idx_q <= 8'h0;
        end else if (hready) begin
            rd_dp_q <= hsel && htrans[1] && !hwrite;
            wr_dp_q <= hsel && htrans[1] && hwrite;
            idx_q <= haddr[9:2];
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_valid_lat; phase_in_valid |-> ##2 phase_out_valid; endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("output valid missing");
    property p_ghost; phase_out_valid |-> $past(phase_in_valid, 2); endproperty
    a_ghost: assert property (p_ghost) else $error("output valid without input");
    property p_rate; phase_in_valid ##1 phase_in_valid |-> ##1 phase_out_valid [*2]; endproperty
    a_rate: assert property (p_rate) else $error("back to back samples lost");
    // equal samples under equal settings must give equal results
    property p_repeat;
        phase_in_valid && $past(phase_in_valid) && $stable(phase_in) && !wr_dp_q
        && $stable(supplementary_frame) && $stable(emitter_temperature)
        && $stable(die_temperature) && !$past(wr_dp_q) |-> ##2 $stable(phase_out);
    endproperty
    a_repeat: assert property (p_repeat) else $error("same sample gave new result");
    property p_f5_hi; rd_dp_q && idx_q == IDX_SUPP_OFFSET |-> hrdata[31:13] == 19'h0; endproperty
    a_f5_hi: assert property (p_f5_hi) else $error("offset upper bits not zero");
    property p_f7_hi; rd_dp_q && idx_q == IDX_EMIT_COEFF |-> hrdata[31:17] == 15'h0; endproperty
    a_f7_hi: assert property (p_f7_hi) else $error("coefficient upper bits set");
    property p_width; rd_dp_q |-> hrdata[31:24] == 8'h0; endproperty
    a_width: assert property (p_width) else $error("read data wider than register");
    property p_idle; !rd_dp_q |-> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside data phase");
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the phase correction stage
`timescale 1ns/1ps
module tb_top;
    import phase_corr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, phase_out_valid;
    logic [31:0] hrdata, rd_smp;
    logic [11:0] phase_in = 12'h0;
    logic [11:0] phase_out;
    logic phase_in_valid = 1'b0;
    logic supplementary_frame = 1'b0;
    logic [7:0] emitter_temperature = 8'h0;
    logic [7:0] die_temperature = 8'h0;
    // shadows of what software wrote, for the expected results
    logic [23:0] s_supp = 24'h0;
    logic [23:0] s_ctrl = CTRL_RESET;
    logic [23:0] s_emit = 24'h0;
    logic [23:0] s_cal = 24'h0;
    logic [23:0] s_base = BASE_RESET;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 hclk = ~hclk;
    phase_temp_correction #(.PHASE_WIDTH(12)) i_phase_temp_correction (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp, .phase_in, .phase_in_valid, .supplementary_frame,
        .emitter_temperature, .die_temperature, .phase_out, .phase_out_valid);
    // read data taken at the edge that ends the data phase, free of races
    always @(posedge hclk) rd_smp <= hrdata;
    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; a read compares against d
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1;
        if (wr && idx == IDX_SUPP_OFFSET) s_supp = d[23:0];
        if (wr && idx == IDX_CTRL) s_ctrl = d[23:0];
        if (wr && idx == IDX_EMIT_COEFF) s_emit = d[23:0];
        if (wr && idx == IDX_CAL_TEMPS) s_cal = d[23:0];
        if (wr && idx == IDX_BASE_OFFSET) s_base = d[23:0];
        chk("hresp", {31'h0, hresp}, 32'h0);
        if (!wr) chk("hrdata", rd_smp, d);
    endtask
    // expected output; only precision values of eight and above are used
    function automatic int model(int ph, logic supp, logic [7:0] te, logic [7:0] td);
        int c, k, ce, cd;
        k = int'(s_ctrl[23:20]) - 8;
        ce = int'($signed(s_emit[16:0])) * (int'($signed(te)) - int'($signed(s_cal[15:8])));
        cd = int'($signed(s_ctrl[16:0])) * (int'($signed(td)) - int'($signed(s_cal[7:0])));
        c = supp ? int'($signed(s_supp[12:0])) : int'($signed(s_base[12:0]));
        if (s_ctrl[17]) c = 0;
        if (!s_ctrl[18]) c += (ce <<< k) + (cd <<< k);
        c += ph;
        if (!s_ctrl[19]) return c & 4095;
        return c < 0 ? 0 : (c > 4095 ? 4095 : c);
    endfunction
    // two equal samples back to back, each checked in its own output cycle
    task automatic smp(input int ph, input logic supp, input logic [7:0] te, input logic [7:0] td);
        int e;
        e = model(ph, supp, te, td);
        @(posedge hclk);
        phase_in <= ph[11:0];
        phase_in_valid <= 1'b1;
        supplementary_frame <= supp;
        emitter_temperature <= te;
        die_temperature <= td;
        repeat (2) @(posedge hclk);
        phase_in_valid <= 1'b0;
        #1;
        chk("phase_out", {20'h0, phase_out}, e);
        chk("phase_out_valid", {31'h0, phase_out_valid}, 32'h1);
        @(posedge hclk);
        #1;
        chk("phase_out", {20'h0, phase_out}, e);
        chk("phase_out_valid", {31'h0, phase_out_valid}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(0, IDX_SUPP_OFFSET, 32'h0);
        bus(0, IDX_CTRL, 32'h00880000);
        bus(0, IDX_EMIT_COEFF, 32'h0);
        bus(0, IDX_CAL_TEMPS, 32'h0);
        bus(0, IDX_BASE_OFFSET, {8'h00, BASE_RESET});
        bus(0, 8'h10, 32'h0);
    endtask
    task automatic t_regs();
        bus(1, IDX_SUPP_OFFSET, 32'h00001FFB);
        bus(0, IDX_SUPP_OFFSET, 32'h00001FFB);
        bus(1, IDX_CTRL, 32'h00880003);
        bus(0, IDX_CTRL, 32'h00880003);
        bus(1, IDX_EMIT_COEFF, 32'h0001FFFE);
        bus(0, IDX_EMIT_COEFF, 32'h0001FFFE);
        bus(1, IDX_CAL_TEMPS, 32'h00A50A14);
        bus(0, IDX_CAL_TEMPS, 32'h00A50A14);
    endtask
    task automatic t_math();
        smp(1000, 1, 8'h0C, 8'h1E);
        bus(1, IDX_BASE_OFFSET, 32'h00080064);
        bus(0, IDX_BASE_OFFSET, 32'h00080064);
        smp(1000, 0, 8'h0C, 8'h1E);
        smp(1000, 1, 8'hFA, 8'h14);
        bus(1, IDX_CAL_TEMPS, 32'h005A0A14);
        smp(1000, 1, 8'h0C, 8'h1E);
    endtask
    task automatic t_ctrl();
        bus(1, IDX_CTRL, 32'h00A80003);
        smp(1000, 1, 8'h0A, 8'h15);
        bus(1, IDX_CTRL, 32'h008C0003);
        smp(1000, 1, 8'h0C, 8'h1E);
        bus(1, IDX_CTRL, 32'h008A0003);
        smp(1000, 1, 8'h0C, 8'h1E);
        bus(1, IDX_CTRL, 32'h00880003);
        smp(2, 1, 8'h0A, 8'h14);
        bus(1, IDX_SUPP_OFFSET, 32'h000007FF);
        smp(4094, 1, 8'h0A, 8'h14);
    endtask
    task automatic final_report();
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_math();
        t_ctrl();
        final_report();
    end
endmodule
bind phase_temp_correction phase_corr_monitor #(.PHASE_WIDTH(PHASE_WIDTH)) i_phase_corr_monitor (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .phase_in,
    .phase_in_valid, .supplementary_frame, .emitter_temperature, .die_temperature,
    .phase_out, .phase_out_valid);
